//--- bench/cfg_host_model.sv
// Behavioural root complex that issues configuration accesses to the block.
// Assumes the block takes a request on one rising edge and acks on the next.
`timescale 1ns/10ps
module cfg_host_model (
    input wire logic core_clk,
    output logic cfg_req,
    output logic cfg_wr,
    output logic [11:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    // The port starts idle, so nothing is taken while reset is held.
    initial begin
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 12'h000;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
    end

    // One access; the request stands for exactly one sampling edge.
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                        input logic [31:0] wd);
        @(negedge core_clk);
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = wd;
        @(negedge core_clk);
        // Released lines show inverted values, so stale data never passes as valid.
        cfg_req = 1'b0;
        cfg_wr = ~wr;
        cfg_addr = ~addr;
        cfg_be = ~be;
        cfg_wdata = ~wd;
    endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the capability and control configuration words.
// Assumes the host model drives the access port and this bench the rest.
`timescale 1ns/10ps
module tb
    import devcap_pkg::*;
;
    logic core_clk, rst_n, cfg_req, cfg_wr, cfg_ack, msg_valid;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [9:0] msg_payload;
    logic setting_a_wr, setting_b_wr;
    logic [2:0] setting_a, setting_b, phy_l1_exit_lat, phy_l0s_exit_lat;
    logic [15:0] dev_ctrl;
    logic [1:0] captured_power_scale;
    logic [7:0] captured_power_value;
    logic [17:0] slot_power_mw;
    int err_total = 0;
    int checked = 0;
    int seed = 98;
    logic [31:0] exp_q[$]; // Expected read data, oldest first.
    logic [15:0] ctrl_exp = 16'h2810; // Our own image of the control word.
    logic [1:0] sc_exp = 2'h0;
    logic [7:0] val_exp = 8'h00;
    logic [2:0] l1_exp = 3'h7;
    logic [2:0] l0s_exp = 3'h7;

    cfg_host_model host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    devcap_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .msg_valid(msg_valid), .msg_payload(msg_payload),
        .setting_a_wr(setting_a_wr), .setting_a(setting_a), .setting_b_wr(setting_b_wr),
        .setting_b(setting_b), .phy_l1_exit_lat(phy_l1_exit_lat),
        .phy_l0s_exit_lat(phy_l0s_exit_lat), .dev_ctrl(dev_ctrl),
        .captured_power_scale(captured_power_scale),
        .captured_power_value(captured_power_value), .slot_power_mw(slot_power_mw));

    // The clock toggles every half period of 2 ns.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Compares one value; case inequality keeps unknowns from matching.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The capability word as the field layout says it should read.
    function automatic logic [31:0] cap_word();
        return {3'h0, 1'b0, sc_exp, val_exp, 2'h0, 1'b1, 3'h0, l1_exp, l0s_exp, 3'h0, 3'h3};
    endfunction

    // Every ack retires the oldest note; reads sampled once outputs have settled.
    always @(negedge core_clk) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected ack", 32'h1, 32'h0);
            end else begin
                check("cfg_rdata", cfg_rdata, exp_q.pop_front());
            end
        end
    end

    // A read of one dword with a random pattern on the unused write lines.
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        host.xfer(1'b0, addr, 4'hF, $random(seed));
    endtask

    // A control write; bytes not enabled keep their old contents.
    task automatic ctrl_wr(input logic [3:0] be, input logic [31:0] wd);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        ctrl_exp = ((ctrl_exp & ~m) | (wd[15:0] & m)) & CTRL_WMASK;
        exp_q.push_back(32'h0);
        host.xfer(1'b1, 12'h078, be, wd);
        check("dev_ctrl", {16'h0, dev_ctrl}, {16'h0, ctrl_exp});
    endtask

    // A slot power message; the limit lands one cycle after the captured fields.
    task automatic send_msg(input logic [1:0] sc, input logic [7:0] v);
        logic [17:0] mult;
        mult = (sc == 2'h0) ? 18'd1000 : (sc == 2'h1) ? 18'd100 : (sc == 2'h2) ? 18'd10 : 18'd1;
        @(negedge core_clk);
        msg_valid = 1'b1;
        msg_payload = {sc, v};
        sc_exp = sc;
        val_exp = v;
        @(negedge core_clk);
        msg_valid = 1'b0;
        msg_payload = ~msg_payload;
        check("scale", {30'h0, captured_power_scale}, {30'h0, sc});
        check("value", {24'h0, captured_power_value}, {24'h0, v});
        @(negedge core_clk);
        check("slot_power_mw", {14'h0, slot_power_mw}, {14'h0, v * mult});
        rd(12'h074, cap_word());
    endtask

    // A latency setting write; the field never falls below the PHY floor.
    task automatic set_lat(input logic l1, input logic [2:0] v);
        @(negedge core_clk);
        if (l1) begin
            setting_a_wr = 1'b1;
            setting_a = v;
            l1_exp = (v < phy_l1_exit_lat) ? phy_l1_exit_lat : v;
        end else begin
            setting_b_wr = 1'b1;
            setting_b = v;
            l0s_exp = (v < phy_l0s_exit_lat) ? phy_l0s_exit_lat : v;
        end
        @(negedge core_clk);
        setting_a_wr = 1'b0;
        setting_b_wr = 1'b0;
        rd(12'h074, cap_word());
    endtask

    // Main sequence: reset, then each group of behaviour in turn.
    initial begin
        rst_n = 1'b0;
        msg_valid = 1'b0;
        msg_payload = 10'h000;
        setting_a_wr = 1'b0;
        setting_b_wr = 1'b0;
        setting_a = 3'h0;
        setting_b = 3'h0;
        phy_l1_exit_lat = 3'h0;
        phy_l0s_exit_lat = 3'h0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check("dev_ctrl reset", {16'h0, dev_ctrl}, 32'h00002810);
        rd(12'h074, 32'h00008FC3);
        rd(12'h078, 32'h00002810);
        // Control word: full, single-byte and random writes; only the random ones are read back.
        ctrl_wr(4'h3, 32'hFFFFFFFF);
        ctrl_wr(4'h1, 32'h00000000);
        ctrl_wr(4'h2, 32'h0000A5A5);
        for (int i = 0; i < 4; i++) begin
            ctrl_wr(4'($random(seed)), $random(seed));
            rd(12'h078, {16'h0, ctrl_exp});
        end
        // A write to the capability word changes nothing; an unmapped dword reads zero.
        exp_q.push_back(32'h0);
        host.xfer(1'b1, 12'h074, 4'hF, 32'hFFFFFFFF);
        rd(12'h074, cap_word());
        rd(12'h07C, 32'h00000000);
        // Every scale code with a random value, then an extreme value.
        for (int s = 0; s < 4; s++) begin
            send_msg(s[1:0], 8'($random(seed)));
        end
        send_msg(2'h0, 8'hFF);
        // Latency fields below, above and raised by the floor.
        phy_l1_exit_lat = 3'h4;
        phy_l0s_exit_lat = 3'h3;
        set_lat(1'b1, 3'h2);
        set_lat(1'b1, 3'h6);
        set_lat(1'b0, 3'h1);
        set_lat(1'b0, 3'h5);
        phy_l0s_exit_lat = 3'h6;
        l0s_exp = 3'h6;
        @(negedge core_clk);
        rd(12'h074, cap_word());
        // A reset in mid-run returns every captured field to its reset image;
        // the PHY floors stay below 7, so the latency fields come back at 7.
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        sc_exp = 2'h0;
        val_exp = 8'h00;
        l1_exp = 3'h7;
        l0s_exp = 3'h7;
        ctrl_exp = CTRL_RESET;
        check("dev_ctrl mid reset", {16'h0, dev_ctrl}, {16'h0, ctrl_exp});
        check("slot_power_mw mid reset", {14'h0, slot_power_mw}, 32'h0);
        rd(12'h074, cap_word());
        repeat (4) @(negedge core_clk);
        check("queue drained", exp_q.size(), 32'h0);
        wrap_up();
    end

    // Watchdog well beyond the hundred or so cycles the sequence needs.
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
endmodule

//--- verilog/devcap_pkg.sv
// Constants for the device capability and device control configuration words.
// Assumes byte addressing of configuration space and 32-bit aligned dwords.
package devcap_pkg;
    // Configuration byte offsets of the two words.
    localparam logic [11:0] CAP_OFFSET = 12'h074;
    localparam logic [11:0] CTRL_OFFSET = 12'h078;
    // Reset images of both words.
    localparam logic [31:0] CAP_RESET = 32'h00008FC3;
    localparam logic [15:0] CTRL_RESET = 16'h2810;
    // Control bits that software may store; bit 15 and bit 9 always read zero.
    localparam logic [15:0] CTRL_WMASK = 16'h7DFF;
    // Field positions inside the capability word.
    localparam int FUNC_RESET_BIT = 28;
    localparam int SCALE_LSB = 26;
    localparam int VALUE_LSB = 18;
    localparam int ROLE_BIT = 15;
    localparam int L1_LSB = 9;
    localparam int L0S_LSB = 6;
    localparam int WIDE_TAG_BIT = 5;
    localparam int TAG_EXT_LSB = 3;
    localparam int PAYLOAD_LSB = 0;
    // Fixed capability field values.
    localparam logic FUNC_RESET_VAL = 1'b0;
    localparam logic ROLE_VAL = 1'b1;
    localparam logic WIDE_TAG_VAL = 1'b0;
    localparam logic [1:0] TAG_EXT_VAL = 2'h0;
    localparam logic [2:0] PAYLOAD_VAL = 3'h3;
    // Reserved-bit mask of the capability word (31:29, 17:16, 14:12).
    localparam logic [31:0] CAP_RSVD_MASK = 32'hE0037000;
    // Payload positions inside the slot power message.
    localparam int MSG_SCALE_LSB = 8;
    localparam int MSG_VALUE_LSB = 0;
    // Reset value of both acceptable latency fields.
    localparam logic [2:0] L1_RESET = 3'h7;
    localparam logic [2:0] L0S_RESET = 3'h7;
    // Milliwatts per watt, used to express the power limit without fractions.
    localparam logic [17:0] MW_PER_WATT = 18'h003E8;
endpackage

//--- verilog/devcap_regs.sv
// Device capability word and device control word of an endpoint.
// Assumes a configuration access port with byte addresses, single-cycle
// requests and a slot power message strobe, all on core_clk.
`timescale 1ns/10ps

module devcap_regs
    import devcap_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration access port.
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Slot power message strobe and its payload.
    input wire logic msg_valid,
    input wire logic [9:0] msg_payload,
    // Internal latency settings and PHY exit latencies.
    input wire logic setting_a_wr,
    input wire logic [2:0] setting_a,
    input wire logic setting_b_wr,
    input wire logic [2:0] setting_b,
    input wire logic [2:0] phy_l1_exit_lat,
    input wire logic [2:0] phy_l0s_exit_lat,
    // Views for the rest of the function.
    output logic [15:0] dev_ctrl,
    output logic [1:0] captured_power_scale,
    output logic [7:0] captured_power_value,
    output logic [17:0] slot_power_mw
);
    // True when a byte address falls in the dword of a given offset.
    function automatic logic hits(input logic [11:0] addr, input logic [11:0] off);
        hits = (addr[11:2] == off[11:2]);
    endfunction

    // Power limit in milliwatts from value and scale code.
    function automatic logic [17:0] power_mw(input logic [1:0] sc, input logic [7:0] v);
        logic [17:0] mult;
        mult = MW_PER_WATT;
        unique case (sc)
            2'h0: mult = MW_PER_WATT;
            2'h1: mult = 18'h00064;
            2'h2: mult = 18'h0000A;
            2'h3: mult = 18'h00001;
        endcase
        power_mw = 18'({10'h000, v} * mult);
    endfunction

    // Captured slot power fields.
    logic [1:0] scale_ff;
    logic [7:0] value_ff;
    logic [1:0] nxt_scale;
    logic [7:0] nxt_value;
    // Registered power limit.
    logic [17:0] power_ff;
    logic [17:0] nxt_power;
    // Device control storage.
    logic [15:0] ctrl_ff;
    logic [15:0] nxt_ctrl;
    // Read answer registers.
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    // Clamped latency fields, index 0 is L1, index 1 is L0s.
    logic [2:0] lat_q [2];
    logic [2:0] set_val [2];
    logic [2:0] phy_lat [2];
    logic [1:0] set_wr;
    // Assembled capability word.
    logic [31:0] cap_word;

    assign set_wr = {setting_b_wr, setting_a_wr};
    assign set_val[0] = setting_a;
    assign set_val[1] = setting_b;
    assign phy_lat[0] = phy_l1_exit_lat;
    assign phy_lat[1] = phy_l0s_exit_lat;

    // Both latency fields share one clamped-setting structure.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lat
            latency_clamp #(
                .RESET_VAL(gi == 0 ? L1_RESET : L0S_RESET)
            ) u_lat (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .set_wr(set_wr[gi]),
                .set_val(set_val[gi]),
                .phy_lat(phy_lat[gi]),
                .lat_q(lat_q[gi])
            );
        end
    endgenerate

    // Capability word; reserved ranges are left at zero by construction.
    always_comb begin
        cap_word = '0;
        cap_word[FUNC_RESET_BIT] = FUNC_RESET_VAL;
        cap_word[SCALE_LSB +: 2] = scale_ff;
        cap_word[VALUE_LSB +: 8] = value_ff;
        cap_word[ROLE_BIT] = ROLE_VAL;
        cap_word[L1_LSB +: 3] = lat_q[0];
        cap_word[L0S_LSB +: 3] = lat_q[1];
        cap_word[WIDE_TAG_BIT] = WIDE_TAG_VAL;
        cap_word[TAG_EXT_LSB +: 2] = TAG_EXT_VAL;
        cap_word[PAYLOAD_LSB +: 3] = PAYLOAD_VAL;
    end

    // Slot power capture; the message is the only thing that moves these.
    always_comb begin
        nxt_scale = scale_ff;
        nxt_value = value_ff;
        if (msg_valid) begin
            nxt_scale = msg_payload[MSG_SCALE_LSB +: 2];
            nxt_value = msg_payload[MSG_VALUE_LSB +: 8];
        end
        nxt_power = power_mw(scale_ff, value_ff);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scale_ff <= CAP_RESET[SCALE_LSB +: 2];
            value_ff <= CAP_RESET[VALUE_LSB +: 8];
            power_ff <= '0;
        end else begin
            scale_ff <= nxt_scale;
            value_ff <= nxt_value;
            power_ff <= nxt_power;
        end
    end

    // Control word writes honour byte enables; fixed-zero bits never store,
    // so a write of one to the reset-initiate bit is simply dropped.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (cfg_req && cfg_wr && hits(cfg_addr, CTRL_OFFSET)) begin
            if (cfg_be[0]) begin
                nxt_ctrl[7:0] = cfg_wdata[7:0] & CTRL_WMASK[7:0];
            end
            if (cfg_be[1]) begin
                nxt_ctrl[15:8] = cfg_wdata[15:8] & CTRL_WMASK[15:8];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Every request is answered one edge later. Writes to the capability word
    // have no path into any register, which keeps it read-only.
    always_comb begin
        nxt_ack = cfg_req;
        nxt_rdata = '0;
        if (cfg_req && !cfg_wr) begin
            if (hits(cfg_addr, CAP_OFFSET)) begin
                nxt_rdata = cap_word;
            end else if (hits(cfg_addr, CTRL_OFFSET)) begin
                nxt_rdata = {16'h0000, ctrl_ff};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_ack = ack_ff;
    assign cfg_rdata = rdata_ff;
    assign dev_ctrl = ctrl_ff;
    assign captured_power_scale = scale_ff;
    assign captured_power_value = value_ff;
    assign slot_power_mw = power_ff;

    // Capability reads carry no reserved bits.
    property p_rsvd_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_req && !cfg_wr && hits(cfg_addr, CAP_OFFSET))
            |=> cfg_ack && (cfg_rdata & CAP_RSVD_MASK) == 32'h00000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    // Fixed capability fields.
    property p_fixed_fields;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_req && !cfg_wr && hits(cfg_addr, CAP_OFFSET))
            |=> !cfg_rdata[28] && cfg_rdata[15] && cfg_rdata[5:0] == 6'h03;
    endproperty
    a_fixed_fields: assert property (p_fixed_fields) else $error("fixed field wrong");

    // Message capture lands one edge after the strobe.
    property p_msg_capture;
        @(posedge core_clk) disable iff (!rst_n)
        msg_valid |=> captured_power_scale == $past(msg_payload[9:8])
            && captured_power_value == $past(msg_payload[7:0]);
    endproperty
    a_msg_capture: assert property (p_msg_capture) else $error("power capture wrong");

    // Power limit follows captured fields one edge later.
    property p_power;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> slot_power_mw == power_mw($past(scale_ff), $past(value_ff));
    endproperty
    a_power: assert property (p_power) else $error("power limit wrong");

    // Latency fields read back as the clamped settings.
    property p_lat_read;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_req && !cfg_wr && hits(cfg_addr, CAP_OFFSET))
            |=> cfg_rdata[11:9] == $past(lat_q[0]) && cfg_rdata[8:6] == $past(lat_q[1]);
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("latency read wrong");

    // Capability writes leave the word untouched when no other update occurs.
    property p_cap_ignore;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_req && cfg_wr && hits(cfg_addr, CAP_OFFSET) && !msg_valid && set_wr == 2'b00
            && lat_q[0] >= phy_l1_exit_lat && lat_q[1] >= phy_l0s_exit_lat)
            |=> $stable(cap_word);
    endproperty
    a_cap_ignore: assert property (p_cap_ignore) else $error("capability changed by write");

    // Low-byte control write stores masked data.
    property p_ctrl_write;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_req && cfg_wr && hits(cfg_addr, CTRL_OFFSET) && cfg_be[0])
            |=> dev_ctrl[7:0] == $past(cfg_wdata[7:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Control word never shows its fixed-zero bits.
    property p_ctrl_zero;
        @(posedge core_clk) disable iff (!rst_n)
        !dev_ctrl[15] && !dev_ctrl[9];
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control fixed bit set");

    c_msg: cover property (@(posedge core_clk) disable iff (!rst_n) msg_valid ##[1:4] cfg_req);
    c_ctrl: cover property (@(posedge core_clk) disable iff (!rst_n)
        cfg_req && cfg_wr && hits(cfg_addr, CTRL_OFFSET));
    c_clamp: cover property (@(posedge core_clk) disable iff (!rst_n)
        setting_a_wr && setting_a < phy_l1_exit_lat);
endmodule

//--- verilog/latency_clamp.sv
// One acceptable-latency field that never falls below the PHY exit latency.
// Assumes the setting strobe and the PHY latency are synchronous to core_clk.
`timescale 1ns/10ps
module latency_clamp
    import devcap_pkg::*;
#(
    parameter logic [2:0] RESET_VAL = 3'h7
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic set_wr,
    input wire logic [2:0] set_val,
    input wire logic [2:0] phy_lat,
    output logic [2:0] lat_q
);
    // Stored field value.
    logic [2:0] lat_ff;
    // Value for the next edge.
    logic [2:0] nxt_lat;

    // A new setting replaces the field, but both the write and any later rise
    // of the PHY latency are clamped, so the field can never under-promise.
    always_comb begin
        nxt_lat = set_wr ? set_val : lat_ff;
        if (nxt_lat < phy_lat) begin
            nxt_lat = phy_lat;
        end
    end

    // Register the field.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_ff <= RESET_VAL;
        end else begin
            lat_ff <= nxt_lat;
        end
    end

    assign lat_q = lat_ff;

    // The field is never below the PHY latency seen on the previous edge.
    property p_lat_floor;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> lat_ff >= $past(phy_lat);
    endproperty
    a_lat_floor: assert property (p_lat_floor) else $error("latency below PHY floor");

    // A write at or above the floor is taken exactly.
    property p_lat_write;
        @(posedge core_clk) disable iff (!rst_n)
        (set_wr && set_val >= phy_lat) |=> lat_ff == $past(set_val);
    endproperty
    a_lat_write: assert property (p_lat_write) else $error("latency setting lost");
endmodule
